// File: rtl/cag_pkg.sv
// Purpose: Constants for the core address-generation block
// Assumes: 16-bit address space, 8-bit data, byte registers packed in pairs
// Notes: Modes are selected by the decoder; opcode decode covers one byte move
// How it works
// - Immediate call and jump load the 16-bit immediate into the program counter.
// - Vector jump uses bits 1..5 to index table 40H..7FH, fetches target.
// - Register jump copies pair zero into the program counter.
// - Direct addressing uses the 16-bit immediate unchanged as operand address.
// - Short direct uses an 8-bit field within window FE20H..FF1FH.
// - Short direct bit 8 is one for fields 00H..1FH, else zero.
// - Special-register addressing places 8-bit field in region FF00H..FFFFH.
// - Register addressing picks one of eight bytes or four pairs by field.
// - Register indirect uses pointer pair two or three as the address.
// - Opcode 00101011 is a byte move into accumulator from pair two address.
// - Based adds zero-extended offset to pair three, carry dropped.
// - Stack accesses go through stack pointer, confined to high-speed RAM.
// - High-speed RAM is FE20H..FEFFH, special registers FF00H..FFFFH.
// - Relative branch adds signed displacement to next instruction address.
package cag_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [15:0] TABLE_LAST = 16'h007F;
  localparam logic [7:0] SHORT_HIGH_PAGE = 8'hFE;
  localparam logic [7:0] SHORT_SPLIT = 8'h20;
  localparam logic [7:0] SFR_PAGE = 8'hFF;
  localparam logic [15:0] RAM_FIRST = 16'hFE20;
  localparam logic [15:0] RAM_LAST = 16'hFEFF;
  localparam logic [15:0] SFR_FIRST = 16'hFF00;
  localparam logic [15:0] SFR_SHORT_LAST = 16'hFF1F;
  localparam logic [7:0] OP_MOV_A_PAIR_TWO = 8'h2B;
  localparam logic [2:0] REG_ACC = 3'h1;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'hFF00;

  typedef enum logic [2:0] {
    CAG_BR_NONE, CAG_BR_IMM, CAG_BR_VECTOR, CAG_BR_REG, CAG_BR_REL
  } cag_branch_e;

  typedef enum logic [2:0] {
    CAG_OP_NONE, CAG_OP_DIRECT, CAG_OP_SHORT, CAG_OP_SFR,
    CAG_OP_IND_TWO, CAG_OP_IND_THREE, CAG_OP_BASED, CAG_OP_STACK
  } cag_operand_e;

  typedef enum logic [1:0] {
    CAG_ST_IDLE, CAG_ST_VEC_LO, CAG_ST_VEC_HI
  } cag_state_e;

  typedef enum logic [1:0] {
    CAG_SP_HOLD, CAG_SP_PUSH, CAG_SP_POP
  } cag_stack_e;
endpackage

// File: rtl/cag_addr_gen.sv
// Purpose: Branch target and operand address generation for the core
// Assumes: Decoder holds request inputs steady until branch_done for vector jumps
// Notes: Table entries are little-endian, low byte at even address
`timescale 1ns/100ps
`default_nettype none
module cag_addr_gen
  import cag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire cag_branch_e branch_mode,
  input wire logic branch_req,
  input wire logic [15:0] full_immediate_address,
  input wire logic [7:0] relative_displacement,
  input wire logic [15:0] next_instr_addr,
  input wire cag_operand_e operand_mode,
  input wire logic operand_req,
  input wire logic [7:0] operand_field,
  input wire logic [2:0] reg_field,
  input wire logic [15:0] pair_zero,
  input wire logic [15:0] pointer_pair_two,
  input wire logic [15:0] pointer_pair_three,
  input wire cag_stack_e stack_op,
  input wire logic [7:0] table_rdata,
  input wire logic table_rvalid,
  output logic [15:0] pc,
  output logic branch_done,
  output logic busy,
  output logic table_req,
  output logic [15:0] table_addr,
  output logic [15:0] operand_addr,
  output logic operand_valid,
  output logic operand_ram,
  output logic operand_sfr,
  output logic operand_fault,
  output logic [15:0] stack_pointer,
  output logic [2:0] byte_reg_sel,
  output logic [1:0] pair_reg_sel,
  output logic move_acc_from_two,
  output logic [2:0] move_dest_reg
);

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= RAM_FIRST) && (a <= RAM_LAST);
  endfunction

  function automatic logic in_short_sfr(input logic [15:0] a);
    in_short_sfr = (a >= SFR_FIRST) && (a <= SFR_SHORT_LAST);
  endfunction

  cag_state_e state;
  cag_state_e next_state;
  logic [7:0] vec_lo;
  logic [15:0] vec_entry;
  logic [15:0] next_pc;
  logic next_branch_done;

  // Branch target candidates
  wire [15:0] imm_target = full_immediate_address;
  wire [15:0] reg_target = pair_zero;
  wire [15:0] disp_ext = {{8{relative_displacement[7]}}, relative_displacement};
  wire [15:0] rel_target = 16'(next_instr_addr + disp_ext);
  wire [15:0] vec_base = TABLE_BASE | {10'h000, opcode[5:1], 1'b0};
  wire vec_in_table = (vec_base >= TABLE_BASE) && (vec_base <= TABLE_LAST);

  // Operand address candidates
  wire short_hi_page = (operand_field < SHORT_SPLIT);
  wire [15:0] short_addr = {7'h7F, short_hi_page, operand_field};
  wire [15:0] sfr_addr = {SFR_PAGE, operand_field};
  wire [15:0] based_addr = 16'(pointer_pair_three + {8'h00, operand_field});
  wire [15:0] sp_dec = 16'(stack_pointer - 16'h0001);
  wire [15:0] sp_inc = 16'(stack_pointer + 16'h0001);
  wire [15:0] stack_addr = (stack_op == CAG_SP_PUSH) ? sp_dec : stack_pointer;
  wire stack_ok = in_ram(stack_addr);

  logic [15:0] next_operand_addr;
  logic next_operand_fault;

  always_comb begin
    next_operand_fault = 1'b0;
    unique case (operand_mode)
      CAG_OP_NONE: next_operand_addr = operand_addr;
      CAG_OP_DIRECT: next_operand_addr = full_immediate_address;
      CAG_OP_SHORT: next_operand_addr = short_addr;
      CAG_OP_SFR: next_operand_addr = sfr_addr;
      CAG_OP_IND_TWO: next_operand_addr = pointer_pair_two;
      CAG_OP_IND_THREE: next_operand_addr = pointer_pair_three;
      CAG_OP_BASED: next_operand_addr = based_addr;
      CAG_OP_STACK: begin
        next_operand_addr = stack_addr;
        next_operand_fault = !stack_ok;
      end
    endcase
  end

  // Opcode decode for the pair-two byte move
  wire is_mov_two = opcode_valid && (opcode == OP_MOV_A_PAIR_TWO);
  wire operand_go = operand_req || is_mov_two;
  wire [15:0] go_addr = is_mov_two ? pointer_pair_two : next_operand_addr;
  wire go_fault = is_mov_two ? 1'b0 : next_operand_fault;
  wire stack_move = operand_req && (operand_mode == CAG_OP_STACK) && stack_ok && !is_mov_two;

  // Branch sequencing
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_branch_done = 1'b0;
    vec_entry = {table_rdata, vec_lo};
    unique case (state)
      CAG_ST_IDLE: begin
        if (branch_req) begin
          unique case (branch_mode)
            CAG_BR_IMM: begin
              next_pc = imm_target;
              next_branch_done = 1'b1;
            end
            CAG_BR_REG: begin
              next_pc = reg_target;
              next_branch_done = 1'b1;
            end
            CAG_BR_REL: begin
              next_pc = rel_target;
              next_branch_done = 1'b1;
            end
            CAG_BR_VECTOR: begin
              if (vec_in_table) begin
                next_state = CAG_ST_VEC_LO;
              end
            end
            CAG_BR_NONE: next_pc = pc;
            default: next_pc = pc;
          endcase
        end
      end
      CAG_ST_VEC_LO: begin
        if (table_rvalid) begin
          next_state = CAG_ST_VEC_HI;
        end
      end
      CAG_ST_VEC_HI: begin
        if (table_rvalid) begin
          next_pc = vec_entry;
          next_branch_done = 1'b1;
          next_state = CAG_ST_IDLE;
        end
      end
      default: next_state = CAG_ST_IDLE;
    endcase
  end

  assign busy = (state != CAG_ST_IDLE);
  assign table_req = busy;
  assign table_addr = (state == CAG_ST_VEC_HI) ? (vec_base | 16'h0001) : vec_base;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= CAG_ST_IDLE;
      pc <= PC_RESET;
      branch_done <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      branch_done <= next_branch_done;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vec_lo <= 8'h00;
    end else if ((state == CAG_ST_VEC_LO) && table_rvalid) begin
      vec_lo <= table_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      operand_addr <= 16'h0000;
      operand_valid <= 1'b0;
      operand_ram <= 1'b0;
      operand_sfr <= 1'b0;
      operand_fault <= 1'b0;
    end else begin
      operand_valid <= operand_go && !go_fault;
      operand_fault <= operand_go && go_fault;
      if (operand_go) begin
        operand_addr <= go_addr;
        operand_ram <= in_ram(go_addr);
        operand_sfr <= in_short_sfr(go_addr) || (go_addr[15:8] == SFR_PAGE);
      end
    end
  end

  // Stack pointer moves only on legal accesses
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_pointer <= SP_RESET;
    end else if (stack_move && (stack_op == CAG_SP_PUSH)) begin
      stack_pointer <= sp_dec;
    end else if (stack_move && (stack_op == CAG_SP_POP)) begin
      stack_pointer <= sp_inc;
    end
  end

  // Register selection
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_reg_sel <= 3'h0;
      pair_reg_sel <= 2'h0;
      move_acc_from_two <= 1'b0;
      move_dest_reg <= 3'h0;
    end else begin
      byte_reg_sel <= reg_field;
      pair_reg_sel <= reg_field[2:1];
      move_acc_from_two <= is_mov_two;
      move_dest_reg <= is_mov_two ? REG_ACC : reg_field;
    end
  end

  // SHORT_HIGH_PAGE documents the upper byte of the RAM half of the window
  wire unused_page = (SHORT_HIGH_PAGE == 8'hFE);

endmodule
`default_nettype wire

// File: test/cag_addr_gen_properties.sv
// Purpose: Assertions on address generation outputs
// Assumes: Bound to cag_addr_gen
// Notes: Operand checks skip the move opcode override
`timescale 1ns/100ps
`default_nettype none
module cag_addr_gen_properties
  import cag_pkg::*;
(
  input wire logic clk, rst, opcode_valid, branch_req, operand_req, busy,
  input wire logic branch_done, move_acc_from_two,
  input wire logic [7:0] opcode, relative_displacement, operand_field,
  input wire logic [15:0] full_immediate_address, next_instr_addr, pair_zero,
  input wire logic [15:0] pointer_pair_two, pointer_pair_three, pc, operand_addr,
  input wire cag_branch_e branch_mode,
  input wire cag_operand_e operand_mode,
  input wire logic [2:0] reg_field, byte_reg_sel, move_dest_reg,
  input wire logic [1:0] pair_reg_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic br_go, mv, op_go;
  logic [15:0] rel_t, short_ea, based_ea;
  assign br_go = branch_req && !busy;
  assign mv = opcode_valid && opcode == OP_MOV_A_PAIR_TWO;
  assign op_go = operand_req && !mv;
  assign rel_t = next_instr_addr + {{8{relative_displacement[7]}}, relative_displacement};
  assign short_ea = {7'h7F, operand_field < 8'h20, operand_field};
  assign based_ea = pointer_pair_three + {8'h00, operand_field};
  chk_imm_branch: assert property (br_go && branch_mode == CAG_BR_IMM
    |=> branch_done && pc == $past(full_immediate_address)) else $error("imm branch");
  chk_reg_branch: assert property (br_go && branch_mode == CAG_BR_REG
    |=> pc == $past(pair_zero)) else $error("reg branch");
  chk_rel_branch: assert property (br_go && branch_mode == CAG_BR_REL
    |=> pc == $past(rel_t)) else $error("rel branch");
  chk_direct_addr: assert property (op_go && operand_mode == CAG_OP_DIRECT
    |=> operand_addr == $past(full_immediate_address)) else $error("direct");
  chk_short_addr: assert property (op_go && operand_mode == CAG_OP_SHORT
    |=> operand_addr == $past(short_ea)) else $error("short");
  chk_based_addr: assert property (op_go && operand_mode == CAG_OP_BASED
    |=> operand_addr == $past(based_ea)) else $error("based");
  chk_move_decode: assert property (mv |=> move_acc_from_two &&
    move_dest_reg == REG_ACC && operand_addr == $past(pointer_pair_two)) else $error("move");
  chk_reg_select: assert property (1'b1 |=> byte_reg_sel == $past(reg_field) &&
    pair_reg_sel == $past(reg_field) >> 1) else $error("reg sel");
endmodule
`default_nettype wire

// File: test/cag_table_model.sv
// Purpose: Vector table memory for table reads
// Assumes: Entry byte is its address xor 3CH
// Notes: Latency from lat; data scrambles while idle
`timescale 1ns/100ps
`default_nettype none
module cag_table_model (
  input wire logic clk, rst, table_req,
  input wire logic [15:0] table_addr,
  input wire logic [3:0] lat,
  output logic [7:0] table_rdata,
  output logic table_rvalid
);
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (rst || !table_req || table_rvalid) begin
      cnt <= 4'h0;
      table_rvalid <= 1'b0;
      table_rdata <= rst ? 8'h55 : ~table_rdata;
    end else if (cnt == lat) begin
      table_rvalid <= 1'b1;
      table_rdata <= table_addr[7:0] ^ 8'h3C;
    end else begin
      cnt <= cnt + 4'h1;
      table_rdata <= ~table_rdata;
    end
  end
endmodule
`default_nettype wire

// File: test/cpu_address_generation_tb_top.sv
// Purpose: Self-checking bench for address generation
// Assumes: Table model answers vector reads
// Notes: One task per scenario
`timescale 1ns/100ps
`default_nettype none
module cpu_address_generation_tb_top;
  import cag_pkg::*;
  logic clk = 0, rst = 1, opcode_valid = 0, branch_req = 0, operand_req = 0;
  logic [7:0] opcode = 8'h2B, relative_displacement = 0, operand_field = 0, table_rdata;
  logic [15:0] full_immediate_address = 16'hFE00, next_instr_addr = 16'h0005;
  logic [15:0] pair_zero = 16'h1234, pointer_pair_two = 16'hFE40;
  logic [15:0] pointer_pair_three = 16'hFFF0, pc, table_addr, operand_addr, stack_pointer;
  logic [2:0] reg_field = 0, byte_reg_sel, move_dest_reg;
  logic [1:0] pair_reg_sel;
  logic [3:0] lat = 0;
  logic branch_done, busy, table_req, table_rvalid, operand_valid, operand_ram;
  logic operand_sfr, operand_fault, move_acc_from_two;
  cag_branch_e branch_mode = CAG_BR_NONE;
  cag_operand_e operand_mode = CAG_OP_NONE;
  cag_stack_e stack_op = CAG_SP_HOLD;
  int errors = 0, check_count = 0;
  always #2 clk = ~clk;
  cag_addr_gen dut (.*);
  cag_table_model mem (.*);
  task automatic chk(string n, logic [20:0] seen, logic [20:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic br(cag_branch_e m, logic [15:0] imm, logic [7:0] d, logic [15:0] exp);
    branch_mode = m;
    full_immediate_address = imm;
    relative_displacement = d;
    branch_req = 1;
    @(posedge clk) #1;
    chk("pc", {branch_done, pc}, {1'b1, exp});
  endtask
  task automatic vec(logic [7:0] opc, logic [3:0] l, logic [15:0] exp);
    int i;
    @(posedge clk) #1;
    opcode = opc;
    lat = l;
    branch_mode = CAG_BR_VECTOR;
    branch_req = 1;
    @(posedge clk) #1;
    branch_req = 0;
    chk("fetch busy", {busy, table_req}, 2'b11);
    chk("table addr", table_addr, 16'h0040 + {opc[5:1], 1'b0});
    for (i = 0; i < 50 && branch_done !== 1'b1; i++)
      @(posedge clk) #1;
    if (i == 50) begin
      errors++;
      finish_test();
    end
    chk("vector pc", pc, exp);
  endtask
  task automatic op(cag_operand_e m, logic [7:0] f, logic mv, logic [20:0] exp);
    operand_mode = m;
    operand_field = f;
    opcode_valid = mv;
    operand_req = !mv;
    @(posedge clk) #1;
    chk("operand", {move_acc_from_two, operand_fault, operand_valid, operand_ram,
      operand_sfr, operand_addr}, exp);
  endtask
  task automatic st(cag_stack_e s, logic fl, logic [15:0] ea, logic [15:0] sp);
    stack_op = s;
    operand_mode = CAG_OP_STACK;
    opcode_valid = 0;
    operand_req = 1;
    @(posedge clk) #1;
    chk("stack", {operand_fault, operand_valid, stack_pointer}, {fl, !fl, sp});
    if (!fl)
      chk("stack addr", operand_addr, ea);
  endtask
  task automatic t_branch();
    @(posedge clk) #1;
    br(CAG_BR_IMM, 16'hFFFF, 8'h00, 16'hFFFF);
    br(CAG_BR_REG, 16'h0000, 8'h00, 16'h1234);
    br(CAG_BR_REL, 16'h0000, 8'h80, 16'hFF85);
    br(CAG_BR_REL, 16'hFE00, 8'h7F, 16'h0084);
    branch_req = 0;
    vec(8'h3E, 4'h3, 16'h4342);
    vec(8'h00, 4'h0, 16'h7D7C);
    opcode = 8'h2B;
    $display("branch test done");
  endtask
  task automatic t_operand();
    op(CAG_OP_DIRECT, 8'h00, 0, 21'h04FE00);
    op(CAG_OP_SHORT, 8'h00, 0, 21'h05FF00);
    op(CAG_OP_SHORT, 8'h1F, 0, 21'h05FF1F);
    op(CAG_OP_SHORT, 8'h20, 0, 21'h06FE20);
    op(CAG_OP_SHORT, 8'hFF, 0, 21'h06FEFF);
    op(CAG_OP_SFR, 8'h80, 0, 21'h05FF80);
    op(CAG_OP_IND_TWO, 8'h00, 0, 21'h06FE40);
    op(CAG_OP_IND_THREE, 8'h00, 0, 21'h05FFF0);
    op(CAG_OP_BASED, 8'h20, 0, 21'h040010);
    op(CAG_OP_SHORT, 8'h30, 1, 21'h16FE40);
    chk("move dest", move_dest_reg, REG_ACC);
    st(CAG_SP_HOLD, 1, 16'h0000, 16'hFF00);
    st(CAG_SP_PUSH, 0, 16'hFEFF, 16'hFEFF);
    st(CAG_SP_POP, 0, 16'hFEFF, 16'hFF00);
    operand_req = 0;
    for (int r = 0; r < 8; r++) begin
      reg_field = r[2:0];
      @(posedge clk) #1;
      chk("reg sel", {byte_reg_sel, pair_reg_sel}, {r[2:0], r[2:1]});
    end
    $display("operand test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    t_branch();
    t_operand();
    finish_test();
  end
endmodule
bind cag_addr_gen cag_addr_gen_properties chk (.*);
`default_nettype wire
